// [core/fixture_pkg.sv]
// Package: constants and types for the test fixture controller
package fixture_pkg;
  // ==========================================================
  // Register map (AXI4-Lite byte offsets)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] FEAT_OFF   = 8'h04;
  localparam logic [7:0] CAL_OFF    = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  // ==========================================================
  // Control field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DATA_BIT  = 1;
  localparam int CTRL_CMD_LSB   = 4;
  localparam int CTRL_CMD_W     = 3;
  // ==========================================================
  // Word layout
  localparam int FEAT_BITS  = 18;
  localparam int CAL_BITS   = 17;
  localparam int WORD_BITS  = 35;
  // ==========================================================
  // Mode step counts
  localparam logic [4:0] STEPS_HORN    = 5'h03;
  localparam logic [4:0] STEPS_STANDBY = 5'h0C;
  localparam logic [4:0] STEPS_HYST    = 5'h0D;
  localparam logic [4:0] STEPS_HUSH    = 5'h0E;
  localparam logic [4:0] STEPS_CHAMBER = 5'h0F;
  localparam logic [4:0] STEPS_LOWBAT  = 5'h11;
  localparam logic [4:0] STEPS_LOAD    = 5'h12;
  localparam logic [4:0] STEPS_LOCK    = 5'h13;
  // ==========================================================
  // Timing
  localparam int CLK_NS          = 25;
  localparam int PHASE_US        = 100;
  localparam int PHASE_CYC       = (PHASE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STORE_MS        = 10;
  localparam int STORE_CYC       = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int VERIFY_LOW_MS   = 1;
  localparam int VERIFY_LOW_CYC  = (VERIFY_LOW_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    CMD_LOAD    = 3'h0,
    CMD_STANDBY = 3'h1,
    CMD_HYST    = 3'h2,
    CMD_HUSH    = 3'h3,
    CMD_CHAMBER = 3'h4,
    CMD_HORN    = 3'h5,
    CMD_LOWBAT  = 3'h6,
    CMD_LOCK    = 3'h7
  } cmd_t;

  typedef struct packed {
    logic sdata;
    logic sclk;
    logic step;
    logic icon;
  } pins_t;
endpackage

// [core/test_mode_config_loader.sv]
// Fixture controller: steps the detector into a test mode and drives it
`timescale 1ns/1ps
module test_mode_config_loader
  import fixture_pkg::*;
#(
  parameter int PHASE_CYCLES  = PHASE_CYC,
  parameter int STORE_CYCLES  = STORE_CYC,
  parameter int VERIFY_CYCLES = VERIFY_LOW_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             serial_data_pin,
  output logic             serial_clock_pin,
  output logic             mode_step_pin,
  output logic             interconnect_pin,
  input  wire logic        verify_status_out
);

  // ==========================================================
  // Sequencer state
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_ARM     = 4'h1,
    ST_DATAHI  = 4'h2,
    ST_STEPLO  = 4'h3,
    ST_STEPHI  = 4'h4,
    ST_ACT     = 4'h5,
    ST_BITSET  = 4'h6,
    ST_CLKHI   = 4'h7,
    ST_CLKLO   = 4'h8,
    ST_IOHI    = 4'h9,
    ST_IOLO    = 4'hA,
    ST_HOLD    = 4'hB
  } state_t;

  state_t                state_reg,  state_next;
  pins_t                 pins_reg,   pins_next;
  logic [31:0]           timer_reg,  timer_next;
  logic [4:0]            steps_reg,  steps_next;
  logic [5:0]            bit_reg,    bit_next;
  logic                  done_reg,   done_next;
  logic [CTRL_CMD_W-1:0] cmd_reg;
  logic                  dval_reg;
  logic [FEAT_BITS-1:0]  feat_reg;
  logic [CAL_BITS-1:0]   cal_reg;
  logic [1:0]            vsync_reg;
  logic                  aw_got_reg, w_got_reg;
  logic [7:0]            awaddr_reg;
  logic [31:0]           wdata_reg;

  // ==========================================================
  // Command decode
  function automatic logic [4:0] steps_for(input logic [CTRL_CMD_W-1:0] c);
    case (cmd_t'(c))
      CMD_LOAD:    steps_for = STEPS_LOAD;
      CMD_STANDBY: steps_for = STEPS_STANDBY;
      CMD_HYST:    steps_for = STEPS_HYST;
      CMD_HUSH:    steps_for = STEPS_HUSH;
      CMD_CHAMBER: steps_for = STEPS_CHAMBER;
      CMD_HORN:    steps_for = STEPS_HORN;
      CMD_LOWBAT:  steps_for = STEPS_LOWBAT;
      default:     steps_for = STEPS_LOCK;
    endcase
  endfunction

  wire [WORD_BITS-1:0] word       = {cal_reg, feat_reg};
  wire                 busy       = (state_reg != ST_IDLE);
  wire                 timer_done = (timer_reg == 32'h0000_0000);
  wire [4:0]           target     = steps_for(cmd_reg);
  wire                 is_load    = (cmd_t'(cmd_reg) == CMD_LOAD);
  wire                 is_verify  = (cmd_t'(cmd_reg) == CMD_HYST) ||
                                    (cmd_t'(cmd_reg) == CMD_HUSH) ||
                                    (cmd_t'(cmd_reg) == CMD_CHAMBER);
  wire                 is_standby = (cmd_t'(cmd_reg) == CMD_STANDBY);
  wire                 is_io      = (cmd_t'(cmd_reg) == CMD_LOWBAT) ||
                                    (cmd_t'(cmd_reg) == CMD_LOCK);
  wire                 wr_fire    = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire                 start_wr   = wr_fire && (awaddr_reg == CTRL_OFF) &&
                                    wdata_reg[CTRL_START_BIT] && !busy;
  wire                 abort_wr   = wr_fire && (awaddr_reg == CTRL_OFF) &&
                                    !wdata_reg[CTRL_START_BIT] && (state_reg == ST_HOLD);

  // ==========================================================
  // Pin sequencer
  always_comb begin
    state_next = state_reg;
    pins_next  = pins_reg;
    timer_next = timer_done ? 32'h0000_0000 : timer_reg - 32'h0000_0001;
    steps_next = steps_reg;
    bit_next   = bit_reg;
    done_next  = done_reg;
    case (state_reg)
      ST_IDLE: begin
        pins_next = '0;
        if (start_wr) begin
          done_next  = 1'b0;
          steps_next = 5'h00;
          bit_next   = 6'h00;
          pins_next.step = 1'b1;
          timer_next = 32'(PHASE_CYCLES);
          state_next = ST_ARM;
        end
      end
      ST_ARM: if (timer_done) begin
        pins_next.sdata = 1'b1;
        timer_next = 32'(PHASE_CYCLES);
        state_next = ST_DATAHI;
      end
      ST_DATAHI, ST_STEPHI: if (timer_done) begin
        if (steps_reg == target) begin
          timer_next = 32'(PHASE_CYCLES);
          state_next = is_load ? ST_BITSET : ST_ACT;
        end else begin
          pins_next.step = 1'b0;
          timer_next = 32'(PHASE_CYCLES);
          state_next = ST_STEPLO;
        end
      end
      ST_STEPLO: if (timer_done) begin
        pins_next.step = 1'b1;
        steps_next = steps_reg + 5'h01;
        timer_next = 32'(PHASE_CYCLES);
        state_next = ST_STEPHI;
      end
      ST_BITSET: if (timer_done) begin
        pins_next.sdata = word[bit_reg];
        timer_next = 32'(PHASE_CYCLES);
        state_next = ST_CLKHI;
      end
      ST_CLKHI: if (timer_done) begin
        pins_next.sclk = 1'b1;
        timer_next = 32'(PHASE_CYCLES);
        state_next = ST_CLKLO;
      end
      ST_CLKLO: if (timer_done) begin
        pins_next.sclk = 1'b0;
        timer_next = 32'(PHASE_CYCLES);
        if (bit_reg == 6'(WORD_BITS - 1)) begin
          state_next = ST_IOHI;
        end else begin
          bit_next   = bit_reg + 6'h01;
          state_next = ST_BITSET;
        end
      end
      ST_ACT: if (timer_done) begin
        timer_next = 32'(PHASE_CYCLES);
        if (is_io) begin
          pins_next.sdata = dval_reg;
          state_next = ST_IOHI;
        end else if (is_standby) begin
          pins_next.sdata = 1'b0;
          timer_next = 32'(VERIFY_CYCLES);
          state_next = ST_HOLD;
        end else if (is_verify) begin
          pins_next.sdata = 1'b0;
          state_next = ST_IOLO;
        end else begin
          pins_next.sdata = 1'b0;
          state_next = ST_HOLD;
        end
      end
      ST_IOHI: if (timer_done) begin
        pins_next.icon = 1'b1;
        timer_next = 32'(STORE_CYCLES);
        state_next = (cmd_t'(cmd_reg) == CMD_LOWBAT) ? ST_HOLD : ST_IOLO;
      end
      ST_IOLO: if (timer_done) begin
        // Ends either the store pulse or the data-pin verify pulse
        pins_next.icon  = 1'b0;
        pins_next.sdata = 1'b1;
        done_next  = 1'b1;
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        // Standing modes stay until software drops start
        if (timer_done) done_next = 1'b1;
        if (abort_wr) begin
          pins_next  = '0;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ==========================================================
  // AXI4-Lite slave
  wire       rd_ok   = (s_axi_araddr == CTRL_OFF) || (s_axi_araddr == FEAT_OFF) ||
                       (s_axi_araddr == CAL_OFF)  || (s_axi_araddr == STATUS_OFF);
  wire       wr_ok   = (awaddr_reg == CTRL_OFF) || (awaddr_reg == FEAT_OFF) ||
                       (awaddr_reg == CAL_OFF)  || (awaddr_reg == STATUS_OFF);
  wire [31:0] rd_mux =
    (s_axi_araddr == CTRL_OFF) ? {25'h0, cmd_reg, 2'h0, dval_reg, busy} :
    (s_axi_araddr == FEAT_OFF) ? {14'h0, feat_reg} :
    (s_axi_araddr == CAL_OFF)  ? {15'h0, cal_reg} :
    (s_axi_araddr == STATUS_OFF) ? {24'h0, steps_reg, vsync_reg[1], done_reg, busy} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      pins_reg <= '0;
      timer_reg <= 32'h0000_0000;
      steps_reg <= 5'h00;
      bit_reg <= 6'h00;
      done_reg <= 1'b0;
      vsync_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      timer_reg <= timer_next;
      steps_reg <= steps_next;
      bit_reg <= bit_next;
      done_reg <= done_next;
      vsync_reg <= {vsync_reg[0], verify_status_out};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      cmd_reg <= 3'h0;
      dval_reg <= 1'b0;
      feat_reg <= '0;
      cal_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        // Settings are frozen while a sequence runs
        if (!busy && awaddr_reg == CTRL_OFF) begin
          cmd_reg <= wdata_reg[CTRL_CMD_LSB +: CTRL_CMD_W];
          dval_reg <= wdata_reg[CTRL_DATA_BIT];
        end
        if (!busy && awaddr_reg == FEAT_OFF) feat_reg <= wdata_reg[FEAT_BITS-1:0];
        if (!busy && awaddr_reg == CAL_OFF) cal_reg <= wdata_reg[CAL_BITS-1:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Ready lines are registered copies of channel emptiness
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  assign serial_data_pin  = pins_reg.sdata;
  assign serial_clock_pin = pins_reg.sclk;
  assign mode_step_pin    = pins_reg.step;
  assign interconnect_pin = pins_reg.icon;

endmodule // test_mode_config_loader

// [tb/detector_model.sv]
// Detector model: mode stepping, serial capture, store, lock and verify output
`timescale 1ns/1ps
module detector_model (
  input  wire logic   osc,
  input  wire logic   sdata,
  input  wire logic   sclk,
  input  wire logic   step,
  input  wire logic   icon,
  input  wire logic   smoke,
  output logic        verify_out,
  output logic [4:0]  mode,
  output logic [34:0] stored,
  output logic        locked
);
  // ==========
  // Pin filter, bits are {data, clock, step, icon}
  logic [3:0]  s1, s2, f, fp;
  logic [34:0] sh;
  logic [5:0]  cnt;
  logic        armed, hit;
  wire  [3:0]  up = f & ~fp;
  initial begin
    f = 4'h0;
    locked = 1'b0;
    stored = '0;
  end
  assign verify_out = hit | (mode == 5'h11 && f[0] && smoke);
  always @(posedge osc) begin
    s1 <= {sdata, sclk, step, icon};
    s2 <= s1;
    f <= (s1 & s2) | (f & (s1 | s2));
    fp <= f;
    // Both step and data low means the fixture let go: back to base mode
    if (!f[1] && !f[3]) begin
      armed <= 1'b0;
      mode <= 5'h00;
      cnt <= 6'h00;
      hit <= 1'b0;
    end else if (!armed && f[1] && f[3]) begin
      armed <= 1'b1;
    end else if (armed && up[1]) begin
      mode <= mode + 5'h01;
    end
    if (mode == 5'h12 && up[2] && cnt < 6'h23) begin
      sh[cnt] <= f[3];
      cnt <= cnt + 6'h01;
    end
    if (up[0] && mode == 5'h12 && cnt == 6'h23 && !locked) begin
      stored <= sh;
    end
    if (up[0] && mode == 5'h13) begin
      locked <= f[3];
    end
    if (mode >= 5'h0C && mode <= 5'h0F && !f[3]) begin
      hit <= smoke;
    end
  end
endmodule // detector_model

// [tb/test_mode_config_loader_checker.sv]
// Checker: pin sequencing properties of the fixture controller
`timescale 1ns/1ps
module test_mode_config_loader_checker
  import fixture_pkg::*;
#(
  parameter int PHASE_CYCLES = 4,
  parameter int STORE_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_data_pin,
  input wire logic serial_clock_pin,
  input wire logic mode_step_pin,
  input wire logic interconnect_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Phase counters, plain ints so they never wrap within a run
  int   lo_cnt, ic_cnt, nbit;
  logic sclk_q;
  always_ff @(posedge aclk) begin
    sclk_q <= serial_clock_pin;
    lo_cnt <= mode_step_pin ? 0 : lo_cnt + 1;
    ic_cnt <= interconnect_pin ? ic_cnt + 1 : 0;
    nbit <= mode_step_pin ? nbit + int'(serial_clock_pin & ~sclk_q) : 0;
  end
  // ==========
  // Properties
  property p_reset_low;
    disable iff (1'b0) !aresetn |=>
      !(serial_data_pin | serial_clock_pin | mode_step_pin | interconnect_pin);
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("pin high after reset");
  property p_arm;
    $rose(serial_data_pin) |-> mode_step_pin;
  endproperty
  a_arm: assert property (p_arm) else $error("data raised before step");
  property p_step_low;
    $rose(mode_step_pin) |-> lo_cnt >= PHASE_CYCLES;
  endproperty
  a_step_low: assert property (p_step_low) else $error("step low phase short");
  property p_sclk_arm;
    $rose(serial_clock_pin) |-> mode_step_pin && serial_data_pin == $past(serial_data_pin);
  endproperty
  a_sclk_arm: assert property (p_sclk_arm) else $error("clock rise unsettled");
  property p_sclk_hold;
    serial_clock_pin |-> $stable(serial_data_pin);
  endproperty
  a_sclk_hold: assert property (p_sclk_hold) else $error("data moved on clock");
  property p_bits;
    $rose(serial_clock_pin) |-> nbit < WORD_BITS;
  endproperty
  a_bits: assert property (p_bits) else $error("too many serial bits");
  property p_store;
    $rose(interconnect_pin) |-> !serial_clock_pin && (nbit == 0 || nbit == WORD_BITS);
  endproperty
  a_store: assert property (p_store) else $error("store before whole word");
  property p_store_len;
    $fell(interconnect_pin) |-> ic_cnt >= STORE_CYCLES;
  endproperty
  a_store_len: assert property (p_store_len) else $error("store pulse short");
  property p_icon_armed;
    interconnect_pin |-> mode_step_pin;
  endproperty
  a_icon_armed: assert property (p_icon_armed) else $error("icon outside mode");
endmodule // test_mode_config_loader_checker

bind test_mode_config_loader test_mode_config_loader_checker #(
  .PHASE_CYCLES(PHASE_CYCLES), .STORE_CYCLES(STORE_CYCLES)
) u_checker (
  .aclk(aclk), .aresetn(aresetn), .serial_data_pin(serial_data_pin),
  .serial_clock_pin(serial_clock_pin), .mode_step_pin(mode_step_pin),
  .interconnect_pin(interconnect_pin)
);

// [tb/test_mode_config_loader_test.sv]
// Testbench: fixture controller against a detector model over AXI4-Lite
`timescale 1ns/1ps
module test_mode_config_loader_test
  import fixture_pkg::*;
;
  logic        aclk, osc, aresetn, smoke, locked, sdata, sclk, step, icon, verify;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  mode;
  logic [34:0] stored, held;
  logic [16:0] f, c;
  int          n_errors, n_checks;
  // Per command: steps sent and settled {data, icon}
  logic [4:0]  st [8] = '{STEPS_LOAD, STEPS_STANDBY, STEPS_HYST, STEPS_HUSH,
                          STEPS_CHAMBER, STEPS_HORN, STEPS_LOWBAT, STEPS_LOCK};
  logic [1:0]  pe [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h0};
  test_mode_config_loader #(.PHASE_CYCLES(4), .STORE_CYCLES(8), .VERIFY_CYCLES(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_data_pin(sdata), .serial_clock_pin(sclk), .mode_step_pin(step),
    .interconnect_pin(icon), .verify_status_out(verify));
  detector_model u_device (.osc(osc), .sdata(sdata), .sclk(sclk), .step(step),
    .icon(icon), .smoke(smoke), .verify_out(verify), .mode(mode), .stored(stored),
    .locked(locked));
  // ==========
  // Clocks; the device oscillator is unrelated to the bus clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    osc = 1'b0;
    forever #7.3 osc = ~osc;
  end
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Word as the device should store it; bit 17 goes out as FEAT bit 17, which every test write leaves zero
  function automatic logic [34:0] exp_word(input logic [16:0] fe, input logic [16:0] ca);
    exp_word = {ca, 1'b0, fe};
  endfunction
  // Horn check has no verify result, every other mode reports the sensed input
  function automatic logic exp_verify(input logic [2:0] cmd, input logic sm);
    exp_verify = sm && (cmd != CMD_HORN);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (awready) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input logic [2:0] cmd, input logic d);
    wr(CTRL_OFF, {25'h0, cmd, 2'b00, d, 1'b1});
  endtask
  task automatic wait_done();
    do rd_reg(STATUS_OFF); while (rd[1] !== 1'b1);
  endtask
  task automatic leave();
    wr(CTRL_OFF, 32'h0);
    do rd_reg(STATUS_OFF); while (rd[0] !== 1'b0);
    chk("idle pins", {sdata, sclk, step, icon}, 4'h0);
  endtask
  task automatic load();
    wr(FEAT_OFF, {15'h0, f});
    wr(CAL_OFF, {15'h0, c});
    run(CMD_LOAD, 1'b0);
    wait_done();
    chk("load mode", {rd[7:3], mode}, {STEPS_LOAD, STEPS_LOAD});
    rd_reg(FEAT_OFF);
    chk("feature readback", rd, {15'h0, f});
    rd_reg(CAL_OFF);
    chk("calibration readback", rd, {15'h0, c});
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // Watchdog: about fifteen times the expected length of the run
  initial begin
    repeat (80000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  // ==========
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, smoke, aresetn} = 7'h00;
    {awaddr, araddr, wdata} = '0;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(19054));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset pins", {sdata, sclk, step, icon}, 4'h0);
    rd_reg(8'h10);
    chk("unmapped read", {rsp, rd}, {2'b10, 32'h0});
    wr(8'h14, 32'hFFFF_FFFF);
    chk("unmapped write", rsp, 2'b10);
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 17'h1FFFF : (i == 1) ? 17'h0AAAA : 17'($urandom);
      c = (i == 0) ? 17'h1FFFF : (i == 1) ? 17'h15555 : 17'($urandom);
      load();
      chk("stored word", stored, exp_word(f, c));
      leave();
    end
    run(CMD_LOCK, 1'b1);
    wait_done();
    chk("lock set", {rd[7:3], locked}, {STEPS_LOCK, 1'b1});
    rd_reg(CTRL_OFF);
    chk("lock command", {rd[6:4], rd[1:0]}, {CMD_LOCK, 2'b11});
    leave();
    held = stored;
    f = ~held[16:0];
    c = ~held[34:18];
    load();
    chk("locked word", stored, held);
    leave();
    run(CMD_LOCK, 1'b0);
    wait_done();
    chk("lock clear", locked, 1'b0);
    leave();
    for (int k = 1; k < 7; k++) begin
      smoke <= 1'($urandom);
      run(3'(k), 1'b1);
      if (k < 5) begin
        wait_done();
      end else begin
        while (mode !== st[k]) @(posedge aclk);
        repeat (40) @(posedge aclk);
      end
      rd_reg(STATUS_OFF);
      chk("verify", {rd[7:3], rd[2], mode}, {st[k], exp_verify(3'(k), smoke), st[k]});
      chk("mode pins", {sdata, icon}, pe[k]);
      leave();
    end
    report_and_stop();
  end
endmodule // test_mode_config_loader_test
